// *** verilog/mpuap_pkg.sv ***
/*
  Constants, field layouts and carrier types for the region attribute
  and permission block of the memory protection unit.
  Assumes a single core clock with a synchronous active-high reset.
*/
package mpuap_pkg;

  // ----------------------------------------------------------------
  // coprocessor addressing
  // ----------------------------------------------------------------
  localparam logic [3:0] CRN_REGION = 4'h6;
  localparam logic [3:0] CRM_ATTR = 4'h1;
  localparam logic [2:0] OP2_ATTR = 3'h4;
  localparam logic [3:0] CRM_SEL = 4'h2;
  localparam logic [2:0] OP2_SEL = 3'h0;

  // ----------------------------------------------------------------
  // access-control register layout
  // ----------------------------------------------------------------
  localparam int NO_FETCH_BIT = 12;
  localparam int PERM_HI = 10;
  localparam int PERM_LO = 8;
  localparam int TEX_HI = 5;
  localparam int TEX_LO = 3;
  localparam int SHARE_BIT = 2;
  localparam int ATTR_HI_BIT = 1;
  localparam int ATTR_LO_BIT = 0;
  localparam logic [12:0] ATTR_MASK = 13'h173f;
  localparam logic [12:0] ATTR_RESET = 13'h0000;
  localparam logic [3:0] SEL_RESET = 4'h0;

  // ----------------------------------------------------------------
  // data permission codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PERM_NONE = 3'h0;
  localparam logic [2:0] PERM_PRIV = 3'h1;
  localparam logic [2:0] PERM_USER_RO = 3'h2;
  localparam logic [2:0] PERM_FULL = 3'h3;
  localparam logic [2:0] PERM_RSV4 = 3'h4;
  localparam logic [2:0] PERM_PRIV_RO = 3'h5;
  localparam logic [2:0] PERM_ALL_RO = 3'h6;

  // ----------------------------------------------------------------
  // cache policy codes, shared by inner and outer levels
  // ----------------------------------------------------------------
  localparam logic [1:0] POL_NC = 2'h0;
  localparam logic [1:0] POL_WBWA = 2'h1;
  localparam logic [1:0] POL_WT = 2'h2;
  localparam logic [1:0] POL_WB = 2'h3;

  typedef enum logic [1:0] {MT_STRONG, MT_DEVICE, MT_NORMAL, MT_RSVD} mpuap_mem_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic fetch;
    logic write;
    logic priv;
    logic hit;
    logic [3:0] region;
  } mpuap_req_t;

  typedef struct packed {
    mpuap_mem_t mtype;
    logic share;
    logic [1:0] inner;
    logic [1:0] outer;
  } mpuap_attr_t;

  typedef struct packed {
    logic fault;
    logic bg;
    logic fetch;
    logic write;
  } mpuap_res_t;

endpackage : mpuap_pkg

// *** verilog/mpuap_attr_perm.sv ***
/*
  Region attribute and permission logic: per-region access-control
  registers, region selector, attribute decode and permission check.
  Assumes the core presents coprocessor transfers and memory checks as
  one-cycle requests, and that region matching is done outside.
*/
`timescale 1ns/1ps

module mpuap_attr_perm
  import mpuap_pkg::*;
#(
  parameter int NREG = 16
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic cp_valid,
  input wire logic cp_write,
  input wire logic cp_priv,
  input wire logic [3:0] cp_crn,
  input wire logic [3:0] cp_crm,
  input wire logic [2:0] cp_op2,
  input wire logic [31:0] cp_wdata,
  output logic cp_ack_r,
  output logic cp_undef_r,
  output logic [31:0] cp_rdata_r,
  input wire logic mpu_enable,
  input wire logic chk_valid,
  input wire mpuap_req_t chk_req,
  output logic res_valid_r,
  output mpuap_res_t res_r,
  output mpuap_attr_t attr_r
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------

  // read and write rights for one permission code and mode
  function automatic logic [1:0] perm_rw(input logic [2:0] p, input logic priv);
    logic [1:0] grant;
    grant = 2'h0;
    case (p)
      PERM_NONE: grant = 2'h0;
      PERM_PRIV: grant = priv ? 2'h3 : 2'h0;
      PERM_USER_RO: grant = priv ? 2'h3 : 2'h2;
      PERM_FULL: grant = 2'h3;
      PERM_PRIV_RO: grant = priv ? 2'h2 : 2'h0;
      PERM_ALL_RO: grant = 2'h2;
      // reserved codes fault: safest reading of unpredictable
      default: grant = 2'h0;
    endcase
    return grant;
  endfunction : perm_rw

  // memory type and cache policies from type_ext and attribute pair
  function automatic mpuap_attr_t attr_dec(input logic [12:0] a);
    mpuap_attr_t d;
    logic [2:0] type_ext;
    logic [1:0] cb;
    type_ext = a[TEX_HI:TEX_LO];
    cb = {a[ATTR_HI_BIT], a[ATTR_LO_BIT]};
    d.mtype = MT_RSVD;
    d.share = 1'b0;
    d.inner = POL_NC;
    d.outer = POL_NC;
    if (type_ext[2])
    begin
      // both levels use one code table
      d.mtype = MT_NORMAL;
      d.inner = cb;
      d.outer = type_ext[1:0];
      d.share = a[SHARE_BIT];
    end
    else
    begin
      case ({type_ext[1:0], cb})
        4'h0:
        begin
          d.mtype = MT_STRONG;
          d.share = 1'b1;
        end
        4'h1:
        begin
          d.mtype = MT_DEVICE;
          d.share = 1'b1;
        end
        4'h2:
        begin
          d.mtype = MT_NORMAL;
          d.inner = POL_WT;
          d.outer = POL_WT;
          d.share = a[SHARE_BIT];
        end
        4'h3:
        begin
          d.mtype = MT_NORMAL;
          d.inner = POL_WB;
          d.outer = POL_WB;
          d.share = a[SHARE_BIT];
        end
        4'h4:
        begin
          d.mtype = MT_NORMAL;
          d.share = a[SHARE_BIT];
        end
        4'h7:
        begin
          d.mtype = MT_NORMAL;
          d.inner = POL_WBWA;
          d.outer = POL_WBWA;
          d.share = a[SHARE_BIT];
        end
        4'h8:
        begin
          // device memory ignores the share bit
          d.mtype = MT_DEVICE;
          d.share = 1'b0;
        end
        default: d.mtype = MT_RSVD;
      endcase
    end
    return d;
  endfunction : attr_dec

  // ----------------------------------------------------------------
  // register file: selector plus one access-control copy per region
  // ----------------------------------------------------------------
  logic [3:0] sel_r;
  logic [3:0] sel_nxt;
  logic [12:0] attr_reg_r [NREG];
  logic [12:0] attr_reg_nxt [NREG];
  logic cp_ack_nxt;
  logic cp_undef_nxt;
  logic [31:0] cp_rdata_nxt;
  logic hit_attr;
  logic hit_sel;

  assign hit_attr = cp_crn == CRN_REGION && cp_crm == CRM_ATTR && cp_op2 == OP2_ATTR;
  assign hit_sel = cp_crn == CRN_REGION && cp_crm == CRM_SEL && cp_op2 == OP2_SEL;

  // one transfer per cycle; the answer appears on the next edge
  always_comb
  begin
    sel_nxt = sel_r;
    attr_reg_nxt = attr_reg_r;
    cp_ack_nxt = 1'b0;
    cp_undef_nxt = 1'b0;
    cp_rdata_nxt = 32'h0000_0000;
    if (cp_valid && (hit_attr || hit_sel))
    begin
      if (!cp_priv)
      begin
        // user mode never touches these registers
        cp_undef_nxt = 1'b1;
      end
      else
      begin
        cp_ack_nxt = 1'b1;
        if (hit_sel && cp_write)
        begin
          sel_nxt = cp_wdata[3:0];
        end
        else if (hit_sel)
        begin
          cp_rdata_nxt = {28'h0000000, sel_r};
        end
        else if (cp_write)
        begin
          // selector picks the copy; out-of-range select is software's fault
          attr_reg_nxt[sel_r] = cp_wdata[12:0] & ATTR_MASK;
        end
        else
        begin
          cp_rdata_nxt = {19'h00000, attr_reg_r[sel_r]};
        end
      end
    end
    else if (cp_valid && cp_crn == CRN_REGION)
    begin
      // other c6 encodings belong to neighbouring blocks; stay silent
      cp_undef_nxt = 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      sel_r <= SEL_RESET;
      for (int i = 0; i < NREG; i++)
        attr_reg_r[i] <= ATTR_RESET;
      cp_ack_r <= 1'b0;
      cp_undef_r <= 1'b0;
      cp_rdata_r <= 32'h0000_0000;
    end
    else
    begin
      sel_r <= sel_nxt;
      attr_reg_r <= attr_reg_nxt;
      cp_ack_r <= cp_ack_nxt;
      cp_undef_r <= cp_undef_nxt;
      cp_rdata_r <= cp_rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // permission check and attribute output
  // ----------------------------------------------------------------
  logic [12:0] chk_attr;
  logic [1:0] rw;
  logic res_valid_nxt;
  mpuap_res_t res_nxt;
  mpuap_attr_t attr_nxt;

  assign chk_attr = attr_reg_r[chk_req.region];
  assign rw = perm_rw(chk_attr[PERM_HI:PERM_LO], chk_req.priv);

  // a disabled unit passes everything; the miss case wins over any region
  always_comb
  begin
    res_valid_nxt = chk_valid;
    res_nxt = '0;
    attr_nxt = attr_r;
    if (chk_valid)
    begin
      res_nxt.fetch = chk_req.fetch;
      res_nxt.write = chk_req.write && !chk_req.fetch;
      attr_nxt = attr_dec(chk_attr);
      if (mpu_enable && !chk_req.hit)
      begin
        res_nxt.bg = 1'b1;
        res_nxt.fault = 1'b1;
      end
      else if (mpu_enable && chk_req.fetch)
      begin
        res_nxt.fault = !rw[1] || chk_attr[NO_FETCH_BIT];
      end
      else if (mpu_enable)
      begin
        res_nxt.fault = chk_req.write ? !rw[0] : !rw[1];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      res_valid_r <= 1'b0;
      res_r <= '0;
      attr_r <= '0;
    end
    else
    begin
      res_valid_r <= res_valid_nxt;
      res_r <= res_nxt;
      attr_r <= attr_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  user_reg_refused_a: assert property (@(posedge clock) disable iff (rst)
    cp_valid && !cp_priv && (hit_attr || hit_sel) |=> cp_undef_r && !cp_ack_r)
    else $error("user register access not refused");

  sel_write_takes_a: assert property (@(posedge clock) disable iff (rst)
    cp_valid && cp_priv && cp_write && hit_sel |=> sel_r == $past(cp_wdata[3:0]))
    else $error("selector write lost");

  attr_write_lands_a: assert property (@(posedge clock) disable iff (rst)
    cp_valid && cp_priv && cp_write && hit_attr
    |=> attr_reg_r[sel_r] == ($past(cp_wdata[12:0]) & ATTR_MASK))
    else $error("access-control write lost");

  no_fetch_fault_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && mpu_enable && chk_req.hit && chk_req.fetch && chk_attr[12]
    |=> res_valid_r && res_r.fault && res_r.fetch)
    else $error("fetch from no-fetch region passed");

  perm_none_fault_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && mpu_enable && chk_req.hit && chk_attr[10:8] == 3'h0 |=> res_r.fault)
    else $error("no-access region passed");

  user_ro_write_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && mpu_enable && chk_req.hit && !chk_req.fetch && !chk_req.priv
    && chk_attr[10:8] == 3'h2 |=> res_r.fault == $past(chk_req.write))
    else $error("user read-only check wrong");

  full_access_pass_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && mpu_enable && chk_req.hit && !chk_req.fetch && chk_attr[10:8] == 3'h3
    |=> !res_r.fault)
    else $error("full-access region faulted");

  miss_bg_fault_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && mpu_enable && !chk_req.hit |=> res_r.bg && res_r.fault)
    else $error("miss without background fault");

  strong_order_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && chk_attr[5:0] == 6'h00 |=> attr_r.mtype == MT_STRONG && attr_r.share)
    else $error("strongly-ordered decode wrong");

  cacheable_split_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && chk_attr[5] |=> attr_r.mtype == MT_NORMAL
    && attr_r.outer == $past(chk_attr[4:3]) && attr_r.inner == $past(chk_attr[1:0]))
    else $error("cacheable policy split wrong");

  // neighbouring c6 registers live elsewhere, so this block must stay quiet
  foreign_silent_a: assert property (@(posedge clock) disable iff (rst)
    cp_valid && !hit_attr && !hit_sel |=> !cp_ack_r && !cp_undef_r)
    else $error("foreign encoding answered");

  user_sel_hold_a: assert property (@(posedge clock) disable iff (rst)
    cp_valid && !cp_priv && hit_sel |=> $stable(sel_r))
    else $error("user access moved the selector");

  fetch_allowed_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && mpu_enable && chk_req.hit && chk_req.fetch && !chk_attr[NO_FETCH_BIT]
    && chk_attr[PERM_HI:PERM_LO] == PERM_FULL |=> res_valid_r && !res_r.fault)
    else $error("permitted fetch refused");

  ro_write_fault_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && mpu_enable && chk_req.hit && !chk_req.fetch && chk_req.write
    && (chk_attr[PERM_HI:PERM_LO] == PERM_PRIV_RO || chk_attr[PERM_HI:PERM_LO] == PERM_ALL_RO)
    |=> res_r.fault)
    else $error("write to read-only region passed");

  disabled_pass_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && !mpu_enable |=> res_valid_r && !res_r.fault && !res_r.bg)
    else $error("disabled unit raised a fault");

  // exception logic may read the result bits without looking at the valid
  res_idle_zero_a: assert property (@(posedge clock) disable iff (rst)
    !chk_valid |=> !res_valid_r && res_r == '0)
    else $error("result shown without a request");

  device_local_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && chk_attr[TEX_HI:TEX_LO] == 3'h2 && chk_attr[ATTR_HI_BIT:ATTR_LO_BIT] == 2'h0
    |=> attr_r.mtype == MT_DEVICE && !attr_r.share)
    else $error("non-shareable device decode wrong");

  writeback_alloc_a: assert property (@(posedge clock) disable iff (rst)
    chk_valid && chk_attr[TEX_HI:TEX_LO] == 3'h1 && chk_attr[ATTR_HI_BIT:ATTR_LO_BIT] == 2'h3
    |=> attr_r.mtype == MT_NORMAL && attr_r.inner == POL_WBWA && attr_r.outer == POL_WBWA)
    else $error("write-back allocate decode wrong");

endmodule : mpuap_attr_perm

// *** tb/mpuap_core_model.sv ***
/*
  Core model: issues coprocessor transfers and memory checks.
  Assumes one caller at a time, clocked by the core clock.
*/
`timescale 1ns/1ps

module mpuap_core_model
  import mpuap_pkg::*;
(
  input wire logic clock,
  output logic cp_valid,
  output logic cp_write,
  output logic cp_priv,
  output logic [3:0] cp_crn,
  output logic [3:0] cp_crm,
  output logic [2:0] cp_op2,
  output logic [31:0] cp_wdata,
  input wire logic cp_ack_r,
  input wire logic cp_undef_r,
  input wire logic [31:0] cp_rdata_r,
  output logic chk_valid,
  output mpuap_req_t chk_req,
  input wire logic res_valid_r,
  input wire mpuap_res_t res_r,
  input wire mpuap_attr_t attr_r
);
  // ----------------------------------------------------------------
  // idle values at time zero
  // ----------------------------------------------------------------
  initial
  begin
    {cp_valid, cp_write, cp_priv, chk_valid} = 4'h0;
    {cp_crn, cp_crm, cp_op2} = 11'h000;
    cp_wdata = 32'h0;
    chk_req = 8'h00;
  end

  // one-edge transfer; answer read once the taking edge has landed
  task automatic cp_xfer(input logic wr, input logic pr, input logic [3:0] crm,
    input logic [2:0] op2, input logic [31:0] wd, output logic [33:0] ans);
    @(posedge clock);
    cp_valid <= 1'b1;
    cp_write <= wr;
    cp_priv <= pr;
    cp_crn <= CRN_REGION;
    cp_crm <= crm;
    cp_op2 <= op2;
    cp_wdata <= wd;
    @(posedge clock);
    cp_valid <= 1'b0;
    cp_wdata <= ~wd; // released data is scrambled so stale values never match
    #1;
    ans = {cp_ack_r, cp_undef_r, cp_rdata_r};
  endtask : cp_xfer

  // one-edge check request, result and attributes read together
  task automatic check(input mpuap_req_t rq, output logic [11:0] ans);
    @(posedge clock);
    chk_valid <= 1'b1;
    chk_req <= rq;
    @(posedge clock);
    chk_valid <= 1'b0;
    chk_req <= ~rq;
    #1;
    ans = {res_valid_r, res_r, attr_r};
  endtask : check
endmodule : mpuap_core_model

// *** tb/tb_mpuap_attr_perm.sv ***
/*
  Self-checking bench for the region attribute and permission block.
  Assumes the core model drives both request ports of the block.
*/
`timescale 1ns/1ps

module tb_mpuap_attr_perm
  import mpuap_pkg::*;
();
  logic clock, rst, mpu_enable, cp_valid, cp_write, cp_priv, chk_valid;
  logic cp_ack_r, cp_undef_r, res_valid_r;
  logic [3:0] cp_crn, cp_crm;
  logic [2:0] cp_op2;
  logic [31:0] cp_wdata, cp_rdata_r;
  mpuap_req_t chk_req;
  mpuap_res_t res_r;
  mpuap_attr_t attr_r;
  int n_fail, checks;

  // ----------------------------------------------------------------
  // design, core model and clock
  // ----------------------------------------------------------------
  mpuap_attr_perm #(.NREG(16)) uut (.clock, .rst, .cp_valid, .cp_write, .cp_priv,
    .cp_crn, .cp_crm, .cp_op2, .cp_wdata, .cp_ack_r, .cp_undef_r, .cp_rdata_r,
    .mpu_enable, .chk_valid, .chk_req, .res_valid_r, .res_r, .attr_r);
  mpuap_core_model core (.clock, .cp_valid, .cp_write, .cp_priv, .cp_crn, .cp_crm,
    .cp_op2, .cp_wdata, .cp_ack_r, .cp_undef_r, .cp_rdata_r, .chk_valid, .chk_req,
    .res_valid_r, .res_r, .attr_r);

  initial clock = 1'b0;
  always #50 clock = ~clock;

  // ----------------------------------------------------------------
  // expectations and reporting
  // ----------------------------------------------------------------
  function automatic logic exp_fault(input logic [2:0] p, input logic nf, input logic pr,
    input logic [1:0] kind);
    logic rd;
    logic wr;
    rd = p == PERM_USER_RO || p == PERM_FULL || p == PERM_ALL_RO
      || (pr && (p == PERM_PRIV || p == PERM_PRIV_RO));
    wr = p == PERM_FULL || (pr && (p == PERM_PRIV || p == PERM_USER_RO));
    exp_fault = (kind == 2'h2) ? !(rd && !nf) : (kind == 2'h1) ? !wr : !rd;
  endfunction : exp_fault

  // policies are masked off where the type gives them no meaning
  task automatic exp_attr(input logic [5:0] v, output mpuap_attr_t e, output logic [6:0] m);
    e = '{MT_RSVD, 1'b0, POL_NC, POL_NC};
    m = 7'h7f;
    if (v[5])
      e = '{MT_NORMAL, v[2], v[1:0], v[4:3]};
    else
      case ({v[4:3], v[1:0]})
        4'h0: e = '{MT_STRONG, 1'b1, POL_NC, POL_NC};
        4'h1: e = '{MT_DEVICE, 1'b1, POL_NC, POL_NC};
        4'h8: e = '{MT_DEVICE, 1'b0, POL_NC, POL_NC};
        4'h2: e = '{MT_NORMAL, v[2], POL_WT, POL_WT};
        4'h3: e = '{MT_NORMAL, v[2], POL_WB, POL_WB};
        4'h4: e = '{MT_NORMAL, v[2], POL_NC, POL_NC};
        4'h7: e = '{MT_NORMAL, v[2], POL_WBWA, POL_WBWA};
        default: ;
      endcase
    if (e.mtype == MT_STRONG || e.mtype == MT_DEVICE)
      m = 7'h70;
  endtask : exp_attr

  task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic results();
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results

  // a full run needs well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clock);
    n_fail++;
    results();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [33:0] a;
    logic [11:0] q;
    logic [31:0] wd;
    mpuap_attr_t e;
    logic [6:0] m;
    logic [3:0] rg;
    rst = 1'b1;
    mpu_enable = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    core.cp_xfer(1'b0, 1'b1, CRM_SEL, OP2_SEL, 32'h0, a);
    cmp(a, {2'b10, 32'h0});
    core.cp_xfer(1'b1, 1'b0, CRM_ATTR, OP2_ATTR, 32'h3ff, a);
    cmp(a, {2'b01, 32'h0});
    core.cp_xfer(1'b0, 1'b0, CRM_SEL, OP2_SEL, 32'h0, a);
    cmp(a, {2'b01, 32'h0});
    core.cp_xfer(1'b0, 1'b1, CRM_ATTR, 3'h2, 32'h0, a);
    cmp(a, 34'h0);
    core.cp_xfer(1'b0, 1'b1, CRM_ATTR, OP2_ATTR, 32'h0, a);
    cmp(a, {2'b10, 32'h0});
    // every region gets its own pattern, junk in the unused bits
    for (int r = 0; r < 16; r++)
    begin
      rg = r[3:0];
      core.cp_xfer(1'b1, 1'b1, CRM_SEL, OP2_SEL, {28'h0, rg}, a);
      cmp(a, {2'b10, 32'h0});
      wd = {19'h7ffff, rg[3], 1'b1, rg[2:0], 2'h3, 2'h0, rg};
      core.cp_xfer(1'b1, 1'b1, CRM_ATTR, OP2_ATTR, wd, a);
      cmp(a, {2'b10, 32'h0});
    end
    for (int r = 15; r >= 0; r--)
    begin
      rg = r[3:0];
      core.cp_xfer(1'b1, 1'b1, CRM_SEL, OP2_SEL, {28'h0, rg}, a);
      core.cp_xfer(1'b0, 1'b1, CRM_SEL, OP2_SEL, 32'h0, a);
      cmp(a, {2'b10, 28'h0, rg});
      core.cp_xfer(1'b0, 1'b1, CRM_ATTR, OP2_ATTR, 32'h0, a);
      cmp(a, {2'b10, 19'h0, rg[3], 1'b0, rg[2:0], 4'h0, rg});
    end
    // region r carries permission r[2:0] and no_fetch r[3]
    @(posedge clock);
    mpu_enable <= 1'b1;
    for (int r = 0; r < 16; r++)
    begin
      rg = r[3:0];
      for (int k = 0; k < 6; k++)
      begin
        core.check('{k[2:1] == 2, k[2:1] == 1, k[0], 1'b1, rg}, q);
        cmp(34'(q[11:7]), 34'({1'b1, exp_fault(rg[2:0], rg[3], k[0], k[2:1]), 1'b0,
          k[2:1] == 2, k[2:1] == 1}));
      end
    end
    core.check('{1'b0, 1'b1, 1'b0, 1'b0, 4'h3}, q);
    cmp(34'(q[11:7]), 34'h1d);
    @(posedge clock);
    mpu_enable <= 1'b0;
    core.check('{1'b0, 1'b1, 1'b0, 1'b1, 4'h0}, q);
    cmp(34'(q[11:7]), 34'h11);
    // all type, share and attribute combinations on region 0
    core.cp_xfer(1'b1, 1'b1, CRM_SEL, OP2_SEL, 32'h0, a);
    for (int i = 0; i < 64; i++)
    begin
      core.cp_xfer(1'b1, 1'b1, CRM_ATTR, OP2_ATTR, 32'(i[5:0]), a);
      core.check('{1'b0, 1'b0, 1'b1, 1'b1, 4'h0}, q);
      exp_attr(i[5:0], e, m);
      cmp(34'(q[6:0] & m), 34'(e & m));
    end
    results();
  end
endmodule : tb_mpuap_attr_perm
